// >>> hw/rtcef_ev_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// flag events and clears between bus side and flag store
interface rtcef_ev_if;
  logic [3:0] set_ev;
  logic [3:0] rd_clr;
  logic [3:0] wr_clr;
  logic [3:0] irq_clr;
  logic [3:0] flags;
  logic [3:0] irq_st;

  modport ctl_side  (output set_ev, rd_clr, wr_clr, irq_clr, input flags, irq_st);
  modport flag_side (input set_ev, rd_clr, wr_clr, irq_clr, output flags, irq_st);
endinterface : rtcef_ev_if
`default_nettype wire

// >>> hw/rtcef_flags.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// sticky flags and interrupt status, set wins over clear
module rtcef_flags
  import rtcef_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  input  wire logic     ce_i,
  rtcef_ev_if.flag_side ev
);
  logic [NFLAG-1:0] flag_q;
  logic [NFLAG-1:0] st_q;

  assign ev.flags  = flag_q;
  assign ev.irq_st = st_q;

  for (genvar i = 0; i < NFLAG; i++)
  begin : g_flag
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        flag_q[i] <= 1'b0;
        st_q[i]   <= 1'b0;
      end
      else if (ce_i)
      begin
        flag_q[i] <= (flag_q[i] & ~(ev.rd_clr[i] | ev.wr_clr[i])) | ev.set_ev[i];
        st_q[i]   <= (st_q[i] & ~ev.irq_clr[i]) | ev.set_ev[i];
      end
    end
  end
endmodule : rtcef_flags
`default_nettype wire

// >>> hw/rtcef_pkg.sv
`default_nettype none
// ==========================================================
// register map and timing
package rtcef_pkg;
  localparam int          ADR_W        = 20;
  localparam int          NFLAG        = 4;
  localparam logic [19:0] FLAG_ADDR    = 20'hf_fff0;
  localparam logic [19:0] CTRL_ADDR    = 20'hf_ffe0;
  localparam logic [19:0] IRQ_ST_ADDR  = 20'hf_ffe4;
  localparam logic [19:0] IRQ_CLR_ADDR = 20'hf_ffe8;
  localparam logic [19:0] IRQ_EN_ADDR  = 20'hf_ffec;
  // flag index i sits at data bit FLAG_LSB + i
  localparam int          FLAG_LSB     = 4;
  localparam int          OSCILLATOR_FAIL_FLAG_IDX     = 0;
  localparam int          PF_IDX       = 1;
  localparam int          AF_IDX       = 2;
  localparam int          WDF_IDX      = 3;
  localparam int          CTL_MSB      = 2;
  localparam int          OSC_EN_BIT   = 0;
  // flags cleared by a read; oscillator flag is not
  localparam logic [3:0]  RD_CLR_MASK  = 4'b1110;
  localparam logic [2:0]  CTL_RST      = 3'h0;
  localparam logic [7:0]  CTRL_RST     = 8'h01;
  localparam logic [3:0]  IRQ_EN_RST   = 4'h0;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          OSC_WAIT_MS  = 5;
  localparam int          OSC_WAIT_CYC = OSC_WAIT_MS * CLK_HZ / 1000;

  typedef enum logic [1:0]
  {
    OSC_LOAD = 2'b00,
    OSC_WAIT = 2'b01,
    OSC_DONE = 2'b10
  } rtcef_osc_st_t;
endpackage : rtcef_pkg
`default_nettype wire

// >>> hw/rtcef_top.sv
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
module rtcef_top
  import rtcef_pkg::*;
#(
  parameter int OSC_WAIT_CYCLES = OSC_WAIT_CYC
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [19:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        wdog_zero_i,
  input  wire logic        alarm_hit_i,
  input  wire logic        supply_low_i,
  input  wire logic        osc_run_i,
  input  wire logic        osc_fail_kept_i,
  output logic             osc_en_o,
  output logic             osc_fail_o,
  output logic             irq_o
);
  // ==========================================================
  // decode
  function automatic logic hit(input logic [19:0] adr, input logic [19:0] off);
    hit = (adr == off);
  endfunction : hit

  rtcef_ev_if ev ();

  logic             ack_q;
  logic [31:0]      dat_q;
  logic [CTL_MSB:0] ctl_q;
  logic [7:0]       ctrl_q;
  logic [3:0]       en_q;
  logic             irq_q;
  logic             osc_s1_q;
  logic             osc_s2_q;
  logic             seen_q;
  logic [15:0]      cnt_q;
  rtcef_osc_st_t    ost_q;
  rtcef_osc_st_t    ost_d;

  wire        req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire        wr       = req & wb_we_i & wb_sel_i[0];
  wire        rd       = req & ~wb_we_i;
  wire        hit_flag = hit(wb_adr_i, FLAG_ADDR);
  wire        hit_ctrl = hit(wb_adr_i, CTRL_ADDR);
  wire        hit_st   = hit(wb_adr_i, IRQ_ST_ADDR);
  wire        hit_en   = hit(wb_adr_i, IRQ_EN_ADDR);
  wire        hit_clr  = hit(wb_adr_i, IRQ_CLR_ADDR);
  wire [7:0]  flag_rd  = {ev.flags, 1'b0, ctl_q};
  wire [31:0] rd_word  = hit_flag ? {24'h00_0000, flag_rd}
                       : hit_ctrl ? {24'h00_0000, ctrl_q}
                       : hit_st   ? {28'h000_0000, ev.irq_st}
                       : hit_en   ? {28'h000_0000, en_q}
                       : 32'h0000_0000;
  wire        win_end  = (ost_q == OSC_WAIT) & (cnt_q == 16'(OSC_WAIT_CYCLES - 1));
  wire        osc_dead = win_end & ctrl_q[OSC_EN_BIT] & ~seen_q & ~osc_s2_q;
  wire        osc_load = (ost_q == OSC_LOAD) & osc_fail_kept_i;

  // ==========================================================
  // next register values
  wire [31:0]      dat_d  = rd ? rd_word : 32'h0000_0000;
  wire [CTL_MSB:0] ctl_d  = (wr & hit_flag) ? wb_dat_i[CTL_MSB:0] : ctl_q;
  wire [7:0]       ctrl_d = (wr & hit_ctrl) ? wb_dat_i[7:0] : ctrl_q;
  wire [3:0]       en_d   = (wr & hit_en) ? wb_dat_i[3:0] : en_q;
  wire             irq_d  = |(ev.irq_st & en_q);
  wire [15:0]      cnt_d  = (ost_q == OSC_WAIT) ? cnt_q + 16'h0001 : cnt_q;

  // ==========================================================
  // events and clears
  assign ev.set_ev[WDF_IDX]  = wdog_zero_i;
  assign ev.set_ev[AF_IDX]   = alarm_hit_i;
  assign ev.set_ev[PF_IDX]   = supply_low_i;
  assign ev.set_ev[OSCILLATOR_FAIL_FLAG_IDX] = osc_dead | osc_load;
  assign ev.rd_clr  = (rd & hit_flag) ? (ev.flags & RD_CLR_MASK) : 4'h0;
  assign ev.wr_clr  = {3'h0, wr & hit_flag & ~wb_dat_i[FLAG_LSB + OSCILLATOR_FAIL_FLAG_IDX]};
  assign ev.irq_clr = (wr & hit_clr) ? wb_dat_i[3:0] : 4'h0;

  rtcef_flags rtcef_flags_i
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .ev    (ev)
  );

  // ==========================================================
  // oscillator start window
  always_comb
  begin
    ost_d = ost_q;
    case (ost_q)
      OSC_LOAD: ost_d = OSC_WAIT;
      OSC_WAIT: ost_d = win_end ? OSC_DONE : OSC_WAIT;
      OSC_DONE: ost_d = OSC_DONE;
      default:  ost_d = OSC_LOAD;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ost_q    <= OSC_LOAD;
      cnt_q    <= CNT_RST;
      seen_q   <= 1'b0;
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
    end
    else if (ce_i)
    begin
      ost_q    <= ost_d;
      cnt_q    <= cnt_d;
      seen_q   <= seen_q | osc_s2_q;
      osc_s1_q <= osc_run_i;
      osc_s2_q <= osc_s1_q;
    end
  end

  // ==========================================================
  // wishbone slave and registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q  <= 1'b0;
      dat_q  <= 32'h0000_0000;
      ctl_q  <= CTL_RST;
      ctrl_q <= CTRL_RST;
      en_q   <= IRQ_EN_RST;
      irq_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      ack_q  <= req;
      dat_q  <= dat_d;
      ctl_q  <= ctl_d;
      ctrl_q <= ctrl_d;
      en_q   <= en_d;
      irq_q  <= irq_d;
    end
  end

  assign wb_ack_o   = ack_q;
  assign wb_dat_o   = dat_q;
  assign irq_o      = irq_q;
  assign osc_en_o   = ctrl_q[OSC_EN_BIT];
  assign osc_fail_o = ev.flags[OSCILLATOR_FAIL_FLAG_IDX];

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wire rd_flag = ce_i & rd & hit_flag;

  wdf_set_a: assert property (ce_i & wdog_zero_i |=> ev.flags[WDF_IDX])
    else $error("watchdog flag not set");
  wdf_clr_a: assert property (rd_flag & ~wdog_zero_i |=> ~ev.flags[WDF_IDX])
    else $error("watchdog flag survived read");
  af_set_a: assert property (ce_i & alarm_hit_i |=> ev.flags[AF_IDX])
    else $error("alarm flag not set");
  af_clr_a: assert property (rd_flag & ~alarm_hit_i |=> ~ev.flags[AF_IDX])
    else $error("alarm flag survived read");
  pf_flag_a: assert property (ce_i & supply_low_i |=> ev.flags[PF_IDX] ##1
                              (ev.flags[PF_IDX] | $past(rd_flag)))
    else $error("power fail flag lost");
  pf_clr_a: assert property (rd_flag & ~supply_low_i |=> ~ev.flags[PF_IDX])
    else $error("power fail flag survived read");
  osc_keep_a: assert property (rd_flag & ev.flags[OSCILLATOR_FAIL_FLAG_IDX] |=> ev.flags[OSCILLATOR_FAIL_FLAG_IDX])
    else $error("oscillator flag cleared by read");
  osc_win_a: assert property (ce_i & osc_dead |=> osc_fail_o ##1
                              (osc_fail_o | $past(ce_i & ev.wr_clr[OSCILLATOR_FAIL_FLAG_IDX])))
    else $error("oscillator failure not flagged");
  osc_load_a: assert property (ce_i & osc_load |=> osc_fail_o)
    else $error("kept oscillator failure lost");
  osc_clr_a: assert property (ce_i & ev.wr_clr[OSCILLATOR_FAIL_FLAG_IDX] & ~ev.set_ev[OSCILLATOR_FAIL_FLAG_IDX] |=>
                              ~osc_fail_o)
    else $error("oscillator flag not cleared by write");
  osc_wr1_a: assert property (ce_i & wr & hit_flag & osc_fail_o &
                              wb_dat_i[FLAG_LSB + OSCILLATOR_FAIL_FLAG_IDX] |=> osc_fail_o)
    else $error("oscillator flag cleared by writing one");
  rd_keep_a: assert property (rd_flag & ~ev.flags[PF_IDX] & supply_low_i |=>
                              ev.flags[PF_IDX] & wb_ack_o & ~wb_dat_o[FLAG_LSB + PF_IDX])
    else $error("event during read lost");
  irq_lvl_a: assert property (ce_i & |(ev.irq_st & en_q) |=> irq_o)
    else $error("interrupt not raised");
  irq_off_a: assert property (ce_i & ~|(ev.irq_st & en_q) |=> ~irq_o)
    else $error("interrupt without enabled status");
  st_set_a: assert property (ce_i & wdog_zero_i |=> ev.irq_st[WDF_IDX])
    else $error("watchdog status not set");
  ack_one_a: assert property (wb_ack_o & ce_i |=> ~wb_ack_o)
    else $error("ack held two cycles");
  ack_rsp_a: assert property (ce_i & req |=> wb_ack_o)
    else $error("request not acked");
  dat_idle_a: assert property (~wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data outside ack");
  ce_hold_a: assert property (~ce_i |=> $stable(ev.flags) & $stable(wb_ack_o) & $stable(irq_o))
    else $error("state moved while frozen");

  // ==========================================================
  // covers
  flag_rd_c: cover property (rd_flag ##1 wb_ack_o & (wb_dat_o[7:4] != 4'h0));
  osc_fail_c: cover property (osc_dead);
  irq_c: cover property (irq_o);
  osc_load_c: cover property (osc_load);
  rd_evt_c: cover property (rd_flag & supply_low_i);
endmodule : rtcef_top
`default_nettype wire

// >>> verif/rtcef_evsrc.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// event sources: watchdog, alarm, supply, oscillator
module rtcef_evsrc
(
  input  wire logic       clk_i,
  input  wire logic [2:0] fire_i,
  input  wire logic       run_i,
  output logic            wdog_zero_o,
  output logic            alarm_hit_o,
  output logic            supply_low_o,
  output logic            osc_run_o
);
  always_ff @(posedge clk_i)
  begin
    wdog_zero_o  <= fire_i[2];
    alarm_hit_o  <= fire_i[1];
    supply_low_o <= fire_i[0];
  end
  assign osc_run_o = run_i;
endmodule : rtcef_evsrc
`default_nettype wire

// >>> verif/test_rtcef_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
// ==========================================================
// bench for the event flag register
module test_rtcef_top;
  import rtcef_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, run = 0, ce = 1, kept = 0;
  logic [19:0] adr = 0;
  logic [31:0] wdat = 0, rdat;
  logic [2:0]  fire = 0, m;
  logic        ack, irq, osc_en, wz, ah, sl, orun, ofail;
  logic [31:0] exp_q[$];
  logic [31:0] e;
  int          errors = 0, total_checks = 0, seed = 32'h131a_5b48;
  initial forever #50 clk_i = ~clk_i;
  rtcef_evsrc rtcef_evsrc_i (.clk_i(clk_i), .fire_i(fire), .run_i(run), .wdog_zero_o(wz),
    .alarm_hit_o(ah), .supply_low_o(sl), .osc_run_o(orun));
  rtcef_top #(.OSC_WAIT_CYCLES(20)) rtcef_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wdog_zero_i(wz), .alarm_hit_i(ah),
    .supply_low_i(sl), .osc_run_i(orun), .osc_fail_kept_i(kept), .osc_en_o(osc_en),
    .osc_fail_o(ofail), .irq_o(irq));
  // ==========================================================
  // bus cycle, expectation noted first
  task automatic bus(input logic w, input logic [19:0] a, input logic [7:0] d,
    input logic [31:0] x);
    @(posedge clk_i);
    exp_q.push_back(x);
    cyc  <= 1;
    stb  <= 1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    cyc <= 0;
    stb <= 0;
  endtask : bus
  task automatic pulse(input logic [2:0] v);
    @(posedge clk_i);
    fire <= v;
    @(posedge clk_i);
    fire <= 0;
    repeat (4) @(posedge clk_i);
  endtask : pulse
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // ==========================================================
  // result watcher
  always @(posedge clk_i)
    if (ack === 1'b1)
    begin
      e = exp_q.pop_front();
      `CHK("read data", e, rdat)
    end
  initial
  begin
    repeat (3000) @(posedge clk_i);
    errors++;
    complete_run();
  end
  // ==========================================================
  // tests
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    repeat (40) @(posedge clk_i);
    `CHK("osc enable", 1'b1, osc_en)
    `CHK("osc fail out", 1'b1, ofail)
    bus(0, CTRL_ADDR, 0, 32'h1);
    bus(0, FLAG_ADDR, 0, 32'h10);
    bus(0, FLAG_ADDR, 0, 32'h10);
    bus(0, IRQ_ST_ADDR, 0, 32'h1);
    bus(1, FLAG_ADDR, 8'h00, 32'h0);
    bus(0, FLAG_ADDR, 0, 32'h0);
    `CHK("osc fail cleared", 1'b0, ofail)
    bus(1, IRQ_CLR_ADDR, 8'h0f, 32'h0);
    $display("oscillator test done");
    for (int i = 0; i < 5; i++)
    begin
      m = (i == 0) ? 3'h7 : 3'($random(seed));
      pulse(m);
      bus(0, FLAG_ADDR, 0, {24'h0, m, 5'h0});
      bus(0, FLAG_ADDR, 0, 32'h0);
    end
    $display("event test done");
    bus(1, IRQ_CLR_ADDR, 8'h0f, 32'h0);
    bus(1, IRQ_EN_ADDR, 8'h08, 32'h0);
    pulse(3'h4);
    `CHK("irq high", 1'b1, irq)
    ce <= 0;
    pulse(3'h2);
    `CHK("irq frozen", 1'b1, irq)
    ce <= 1;
    bus(0, IRQ_ST_ADDR, 0, 32'h8);
    bus(1, IRQ_CLR_ADDR, 8'h08, 32'h0);
    repeat (2) @(posedge clk_i);
    `CHK("irq cleared", 1'b0, irq)
    pulse(3'h3);
    `CHK("irq masked", 1'b0, irq)
    bus(0, FLAG_ADDR, 0, 32'he0);
    bus(0, 20'h0_0010, 0, 32'h0);
    $display("interrupt test done");
    @(posedge clk_i);
    fire <= 3'h1;
    bus(0, FLAG_ADDR, 0, 32'h0);
    fire <= 3'h0;
    bus(0, FLAG_ADDR, 0, 32'h20);
    bus(0, FLAG_ADDR, 0, 32'h0);
    $display("read event test done");
    pulse(3'h7);
    kept  <= 1;
    run   <= 1;
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    repeat (30) @(posedge clk_i);
    `CHK("osc fail kept", 1'b1, ofail)
    bus(0, FLAG_ADDR, 0, 32'h10);
    bus(1, FLAG_ADDR, 8'h10, 32'h0);
    bus(0, FLAG_ADDR, 0, 32'h10);
    bus(1, FLAG_ADDR, 8'h00, 32'h0);
    bus(0, FLAG_ADDR, 0, 32'h0);
    `CHK("osc fail cleared", 1'b0, ofail)
    `CHK("irq after restart", 1'b0, irq)
    $display("restart test done");
    repeat (3) @(posedge clk_i);
    complete_run();
  end
endmodule : test_rtcef_top
`default_nettype wire
